/* File: motion_params.svh */
// Constants for the jog and homing motion block.
`ifndef MOTION_PARAMS_SVH
`define MOTION_PARAMS_SVH
`define HOME_DOG 4'h0
`define HOME_COUNT 4'h1
`define HOME_DATA_SET 4'h2
`define HOME_STOPPER 4'h3
`define HOME_IGNORE 4'h4
`define HOME_DOG_REAR 4'h5
`define STALL_TIME_MS 100
`define STALL_CYCLES ((`STALL_TIME_MS) * 10000)
`define POS_RESET 32'h0000_0000
`endif

/* File: motion_pkg.sv */
// Types shared by the jog and homing motion block.
package motion_pkg;
	typedef enum logic [1:0] {DIR_STOP, DIR_CCW, DIR_CW} rot_dir_t;
	typedef struct packed {
		logic [15:0] jog_speed;
		logic [15:0] accel_time;
		logic [15:0] decel_time;
		logic direction_map;
	} jog_cfg_t;
	typedef struct packed {
		logic [3:0] method;
		logic [31:0] shift_dist;
		logic [31:0] after_dog_dist;
		logic dir_decrement;
		logic absolute_system;
	} home_cfg_t;
endpackage

/* File: speed_ramp.sv */
// Linear speed ramp toward a target using table entry one ramp times.
`timescale 1ns/1ns
module speed_ramp #(
	parameter int WIDTH = 16
) (
	input wire logic clk_in, // Clock.
	input wire logic srst_in, // Synchronous reset, high.
	input wire logic [WIDTH-1:0] target_in, // Speed to reach.
	input wire logic [15:0] accel_time_in, // Cycles per step up, less one.
	input wire logic [15:0] decel_time_in, // Cycles per step down, less one.
	output logic [WIDTH-1:0] speed_out // Present speed.
);
	logic [WIDTH-1:0] speed_q, speed_d;
	logic [15:0] tick_q, tick_d;

	initial begin
		if (WIDTH < 2) $error("speed_ramp width too small");
	end

	////////////////////////////////////////////////////////////////////////
	// One speed step per ramp interval; a zero time means an instant jump.
	always_comb begin
		speed_d = speed_q;
		tick_d = tick_q + 16'h0001;
		if (speed_q < target_in) begin
			if (accel_time_in == 16'h0000) begin
				speed_d = target_in;
			end else if (tick_q >= accel_time_in) begin
				speed_d = speed_q + {{(WIDTH-1){1'b0}}, 1'b1};
				tick_d = 16'h0000;
			end
		end else if (speed_q > target_in) begin
			if (decel_time_in == 16'h0000) begin
				speed_d = target_in;
			end else if (tick_q >= decel_time_in) begin
				speed_d = speed_q - {{(WIDTH-1){1'b0}}, 1'b1};
				tick_d = 16'h0000;
			end
		end else begin
			tick_d = 16'h0000;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			speed_q <= '0;
			tick_q <= 16'h0000;
		end else begin
			speed_q <= speed_d;
			tick_q <= tick_d;
		end
	end

	assign speed_out = speed_q;
endmodule

/* File: servo_jog_and_homing_modes.sv */
// Manual jog and home position return logic of the servo driver.
// Notes on behaviour
// - Manual select off gives jog mode; the eight table selects are ignored.
// - Map zero: forward is CCW, reverse CW; map one swaps them.
// - Forward start runs at jog speed with table one ramp times.
// - Reverse start turns opposite to forward with the same settings.
// - Absolute systems keep position over power-off; home once only. Here SRST_IN still clears the position and HOME_DONE_OUT.
// - Starting on the dog, the dog-based types back off automatically, then home.
// - Dog type: slow at front edge, home at first Z after rear.
// - Count type: slow at front edge, first Z after preset distance.
// - Data setting type takes the current position as home, no dog.
// - Stopper type takes home where motion halts against the stop.
// - Ignore type takes the servo-on position as home.
// - Rear reference: home after travel plus shift past rear edge.
// - Rear reference homing uses no Z-phase pulse.
`timescale 1ns/1ns
`include "motion_params.svh"
module servo_jog_and_homing_modes #(
	parameter int SPEED_W = 16,
	parameter int STALL_CYCLES = `STALL_CYCLES
) (
	input wire logic SYS_CLK_IN, // 10 MHz clock.
	input wire logic SRST_IN, // Synchronous reset, high.
	input wire logic AUTO_MANUAL_SELECT_IN, // High selects automatic.
	input wire logic [4:0] TABLE_SELECT_LOW_BITS_IN, // Table select low.
	input wire logic [2:0] TABLE_SELECT_HIGH_BITS_IN, // Table select high.
	input wire logic FORWARD_START_IN, // Jog or home start.
	input wire logic REVERSE_START_IN, // Reverse jog start.
	input wire motion_pkg::jog_cfg_t JOG_CFG_IN, // Jog settings.
	input wire motion_pkg::home_cfg_t HOME_CFG_IN, // Homing settings.
	input wire logic SERVO_ON_IN, // Servo on level.
	input wire logic DOG_IN, // Dog detected, polarity applied.
	input wire logic Z_PULSE_IN, // Encoder Z-phase, one cycle.
	input wire logic MOVE_STEP_IN, // One position unit moved.
	output motion_pkg::rot_dir_t DIR_OUT, // Commanded rotation.
	output logic [SPEED_W-1:0] SPEED_OUT, // Commanded speed.
	output logic JOG_MODE_OUT, // Jog mode active.
	output logic HOMING_BUSY_OUT, // Home return running.
	output logic HOME_DONE_OUT, // Home position valid.
	output logic [31:0] POSITION_OUT // Current position.
);
	import motion_pkg::*;

	typedef enum logic [2:0] {
		H_IDLE, H_BACKOFF, H_SEEK, H_PASS, H_TRAVEL, H_ZWAIT, H_SHIFT
	} home_state_t;

	initial begin
		// The jog speed field is 16 bits wide, so wider speeds cannot be fed.
		if (SPEED_W < 2 || SPEED_W > 16) $error("speed width must be 2 to 16");
		if (STALL_CYCLES < 1) $error("stall count must be positive");
	end

	// Direction that a start input produces under the mapping parameter.
	function automatic rot_dir_t map_dir(input logic fwd, input logic swap);
		map_dir = (fwd ^ swap) ? DIR_CCW : DIR_CW;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Mode decode; table selects only matter in automatic mode.
	logic manual_mode, home_sel, jog_sel;
	assign manual_mode = !AUTO_MANUAL_SELECT_IN;
	assign home_sel = AUTO_MANUAL_SELECT_IN &&
		({TABLE_SELECT_HIGH_BITS_IN, TABLE_SELECT_LOW_BITS_IN} == 8'h00);
	assign jog_sel = manual_mode;

	////////////////////////////////////////////////////////////////////////
	// Homing sequence state.
	home_state_t hs_q, hs_d;
	logic [31:0] pos_q, pos_d, cnt_q, cnt_d;
	logic done_q, done_d, dog_q, dog_d, start_q, start_d, son_q, son_d;
	logic [31:0] stall_q, stall_d;
	rot_dir_t hdir, dir_q, dir_d;
	logic fast;
	logic start_rise, son_rise, dog_rise, dog_fall, stalled;
	logic [3:0] m;

	assign m = HOME_CFG_IN.method;
	assign start_rise = FORWARD_START_IN && !start_q;
	assign son_rise = SERVO_ON_IN && !son_q;
	assign dog_rise = DOG_IN && !dog_q;
	assign dog_fall = !DOG_IN && dog_q;
	assign stalled = (stall_q >= STALL_CYCLES);

	// Seek direction follows the increment/decrement choice.
	always_comb begin
		hdir = HOME_CFG_IN.dir_decrement ? DIR_CW : DIR_CCW;
		if (hs_q == H_BACKOFF) begin
			hdir = HOME_CFG_IN.dir_decrement ? DIR_CCW : DIR_CW;
		end
	end

	// Next state of the homing sequence and position counter.
	always_comb begin
		hs_d = hs_q;
		pos_d = pos_q;
		cnt_d = cnt_q;
		done_d = done_q;
		stall_d = 32'h0000_0000;
		fast = 1'b0;
		dog_d = DOG_IN;
		start_d = FORWARD_START_IN;
		son_d = SERVO_ON_IN;
		// Count along the commanded rotation, which lags the seek direction
		// while a reversal winds the speed down.
		if (MOVE_STEP_IN) begin
			pos_d = (dir_q == DIR_CW) ?
				pos_q - 32'h0000_0001 : pos_q + 32'h0000_0001;
		end
		if (son_rise && m == `HOME_IGNORE) begin
			pos_d = `POS_RESET;
			done_d = 1'b1;
		end
		unique case (hs_q)
			H_IDLE: begin
				if (home_sel && start_rise) begin
					if (!HOME_CFG_IN.absolute_system) begin
						done_d = 1'b0;
					end
					if (m == `HOME_DATA_SET) begin
						pos_d = `POS_RESET;
						done_d = 1'b1;
					end else if (m == `HOME_STOPPER) begin
						hs_d = H_SEEK;
					end else if (m != `HOME_IGNORE) begin
						hs_d = DOG_IN ? H_BACKOFF : H_SEEK;
					end
				end
			end
			H_BACKOFF: begin
				fast = 1'b1;
				if (!DOG_IN) begin
					hs_d = H_SEEK;
				end
			end
			H_SEEK: begin
				fast = 1'b1;
				if (m == `HOME_STOPPER) begin
					stall_d = MOVE_STEP_IN ? 32'h0000_0000 :
						stall_q + 32'h0000_0001;
					if (stalled) begin
						pos_d = `POS_RESET;
						done_d = 1'b1;
						hs_d = H_IDLE;
					end
				end else if (dog_rise) begin
					cnt_d = 32'h0000_0000;
					hs_d = (m == `HOME_COUNT) ? H_TRAVEL : H_PASS;
				end
			end
			H_PASS: begin
				if (dog_fall) begin
					cnt_d = 32'h0000_0000;
					hs_d = (m == `HOME_DOG_REAR) ? H_TRAVEL : H_ZWAIT;
				end
			end
			H_TRAVEL: begin
				if (MOVE_STEP_IN) begin
					cnt_d = cnt_q + 32'h0000_0001;
				end
				// Judge with this cycle's step included, so none is lost.
				if (cnt_d >= HOME_CFG_IN.after_dog_dist) begin
					cnt_d = 32'h0000_0000;
					hs_d = (m == `HOME_DOG_REAR) ? H_SHIFT : H_ZWAIT;
				end
			end
			H_ZWAIT: begin
				if (Z_PULSE_IN) begin
					cnt_d = 32'h0000_0000;
					hs_d = H_SHIFT;
				end
			end
			H_SHIFT: begin
				// Rear reference reaches here without any Z-phase wait.
				if (MOVE_STEP_IN) begin
					cnt_d = cnt_q + 32'h0000_0001;
				end
				if (cnt_d >= HOME_CFG_IN.shift_dist) begin
					pos_d = `POS_RESET;
					done_d = 1'b1;
					hs_d = H_IDLE;
				end
			end
		endcase
		if (!home_sel && hs_q != H_IDLE) begin
			hs_d = H_IDLE;
		end
	end

	always_ff @(posedge SYS_CLK_IN) begin
		if (SRST_IN) begin
			hs_q <= H_IDLE;
			pos_q <= `POS_RESET;
			cnt_q <= 32'h0000_0000;
			done_q <= 1'b0;
			stall_q <= 32'h0000_0000;
			dog_q <= 1'b0;
			start_q <= 1'b0;
			son_q <= 1'b0;
		end else begin
			hs_q <= hs_d;
			pos_q <= pos_d;
			cnt_q <= cnt_d;
			done_q <= done_d;
			stall_q <= stall_d;
			dog_q <= dog_d;
			start_q <= start_d;
			son_q <= son_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Jog direction and speed target; the direction is held while the
	// ramp winds down so the motor never reverses under speed.
	logic [SPEED_W-1:0] target, speed;
	logic jog_run;
	assign jog_run = jog_sel && (FORWARD_START_IN ^ REVERSE_START_IN);

	always_comb begin
		dir_d = dir_q;
		target = '0;
		if (jog_run) begin
			dir_d = map_dir(FORWARD_START_IN,
				JOG_CFG_IN.direction_map);
			target = JOG_CFG_IN.jog_speed[SPEED_W-1:0];
		end else if (hs_q != H_IDLE) begin
			dir_d = hdir;
			target = fast ? JOG_CFG_IN.jog_speed[SPEED_W-1:0] :
				{{(SPEED_W-1){1'b0}}, 1'b1};
		end else if (speed == '0) begin
			dir_d = DIR_STOP;
		end
		if (speed != '0 && dir_q != DIR_STOP && dir_d != dir_q) begin
			dir_d = dir_q;
			target = '0;
		end
	end

	always_ff @(posedge SYS_CLK_IN) begin
		if (SRST_IN) begin
			dir_q <= DIR_STOP;
		end else begin
			dir_q <= dir_d;
		end
	end

	speed_ramp #(.WIDTH(SPEED_W)) u_ramp (
		.clk_in(SYS_CLK_IN),
		.srst_in(SRST_IN),
		.target_in(target),
		.accel_time_in(JOG_CFG_IN.accel_time),
		.decel_time_in(JOG_CFG_IN.decel_time),
		.speed_out(speed)
	);

	assign DIR_OUT = dir_q;
	assign SPEED_OUT = speed;
	assign JOG_MODE_OUT = jog_sel;
	assign HOMING_BUSY_OUT = (hs_q != H_IDLE);
	assign HOME_DONE_OUT = done_q;
	assign POSITION_OUT = pos_q;
endmodule

/* File: jog_home_chk_sva.sv */
// Port assertions for the jog and homing block.
`timescale 1ns/1ns
module jog_home_chk #(parameter int SPEED_W = 16) (
	input wire logic SYS_CLK_IN, // Clock.
	input wire logic SRST_IN, // Reset.
	input wire logic AUTO_MANUAL_SELECT_IN, // Auto high.
	input wire logic [4:0] TABLE_SELECT_LOW_BITS_IN, // Select.
	input wire logic [2:0] TABLE_SELECT_HIGH_BITS_IN, // Select.
	input wire logic FORWARD_START_IN, // Forward.
	input wire logic REVERSE_START_IN, // Reverse.
	input wire motion_pkg::jog_cfg_t JOG_CFG_IN, // Jog set.
	input wire motion_pkg::home_cfg_t HOME_CFG_IN, // Home set.
	input wire logic SERVO_ON_IN, // Servo on.
	input wire motion_pkg::rot_dir_t DIR_OUT, // Direction.
	input wire logic [SPEED_W-1:0] SPEED_OUT, // Speed.
	input wire logic JOG_MODE_OUT, // Jog mode.
	input wire logic HOMING_BUSY_OUT, // Busy.
	input wire logic HOME_DONE_OUT, // Done.
	input wire logic [31:0] POSITION_OUT // Position.
);
import motion_pkg::*;
// Home mode is automatic with all eight table selects clear.
wire logic hm = AUTO_MANUAL_SELECT_IN &&
	{TABLE_SELECT_HIGH_BITS_IN, TABLE_SELECT_LOW_BITS_IN} == 8'h00;
wire logic nh = !hm;
wire logic f = FORWARD_START_IN;
wire logic r = REVERSE_START_IN;
wire logic m = JOG_CFG_IN.direction_map;
wire logic jm = JOG_MODE_OUT;
wire logic both = f && r;
// Both starts or neither gives a zero target, so speed may only fall.
wire logic hold = jm && (f == r);
default clocking cb @(posedge SYS_CLK_IN); endclocking
default disable iff (SRST_IN);
////////////////////////////////////////////////////////////////////////
chk_mode_decode: assert property (jm == !AUTO_MANUAL_SELECT_IN)
	else $error("jog mode decode wrong");
chk_fwd_map: assert property (
	jm && $rose(f) && !r && DIR_OUT == DIR_STOP
	|-> ##[1:2] DIR_OUT == (m ? DIR_CW : DIR_CCW)) else $error("fwd dir");
chk_rev_map: assert property (
	jm && $rose(r) && !f && DIR_OUT == DIR_STOP
	|-> ##[1:2] DIR_OUT == (m ? DIR_CCW : DIR_CW)) else $error("rev dir");
chk_ramp_down: assert property (
	hold && $past(hold) && $past(hold, 2)
	|=> SPEED_OUT <= $past(SPEED_OUT)) else $error("speed rose");
chk_both_still: assert property (
	jm && both && $past(both) && DIR_OUT == DIR_STOP
	|=> DIR_OUT == DIR_STOP) else $error("both starts turned");
chk_speed_cap: assert property (
	jm && $past(jm) |-> SPEED_OUT <= JOG_CFG_IN.jog_speed)
	else $error("above jog speed");
chk_stop_rest: assert property (
	jm && $past(jm) && DIR_OUT == DIR_STOP && $past(DIR_OUT) != DIR_STOP
	|-> SPEED_OUT == 0) else $error("stopped while moving");
chk_abort_home: assert property (
	nh && $past(nh) |-> !HOMING_BUSY_OUT) else $error("busy outside home");
chk_data_home: assert property (
	hm && HOME_CFG_IN.method == 4'h2 && $rose(f) && !HOMING_BUSY_OUT
	|-> ##[1:4] HOME_DONE_OUT && POSITION_OUT == 32'h0)
	else $error("data set home late");
chk_servo_home: assert property (
	hm && HOME_CFG_IN.method == 4'h4 && $rose(SERVO_ON_IN) && !HOMING_BUSY_OUT
	|-> ##[1:4] HOME_DONE_OUT && POSITION_OUT == 32'h0)
	else $error("servo on home late");
chk_abs_keep: assert property (
	HOME_CFG_IN.absolute_system && HOME_DONE_OUT |=> HOME_DONE_OUT)
	else $error("done lost in absolute system");
cov_jog_cw: cover property (jm && DIR_OUT == DIR_CW);
cov_both: cover property (jm && both && SPEED_OUT != 0);
cov_home: cover property ($rose(HOME_DONE_OUT));
endmodule
bind servo_jog_and_homing_modes jog_home_chk #(.SPEED_W(SPEED_W)) chk_u (
	.SYS_CLK_IN(SYS_CLK_IN),
	.SRST_IN(SRST_IN),
	.AUTO_MANUAL_SELECT_IN(AUTO_MANUAL_SELECT_IN),
	.TABLE_SELECT_LOW_BITS_IN(TABLE_SELECT_LOW_BITS_IN),
	.TABLE_SELECT_HIGH_BITS_IN(TABLE_SELECT_HIGH_BITS_IN),
	.FORWARD_START_IN(FORWARD_START_IN),
	.REVERSE_START_IN(REVERSE_START_IN),
	.JOG_CFG_IN(JOG_CFG_IN),
	.HOME_CFG_IN(HOME_CFG_IN),
	.SERVO_ON_IN(SERVO_ON_IN),
	.DIR_OUT(DIR_OUT),
	.SPEED_OUT(SPEED_OUT),
	.JOG_MODE_OUT(JOG_MODE_OUT),
	.HOMING_BUSY_OUT(HOMING_BUSY_OUT),
	.HOME_DONE_OUT(HOME_DONE_OUT),
	.POSITION_OUT(POSITION_OUT)
);

/* File: axis_model.sv */
// Behavioural axis with a dog cam, encoder Z marks and a hard stop.
`timescale 1ns/1ns
module axis_model #(parameter int DOG_LO = 200, parameter int DOG_HI = 240,
	parameter int Z_EVERY = 16) (
	input wire logic clk_in, // Clock.
	input wire logic z_en_in, // Z marks enabled.
	input wire motion_pkg::rot_dir_t dir_in, // Commanded rotation.
	input wire logic [15:0] speed_in, // Commanded speed.
	output logic step_out, // One unit moved.
	output logic dog_out, // Dog detected.
	output logic z_out // Z mark.
);
import motion_pkg::*;
int pos = 0;
int nx;
logic ph = 1'b0;
// One step every other cycle; the stop at zero stalls CW motion there.
always @(posedge clk_in) begin
	step_out <= 1'b0;
	z_out <= 1'b0;
	ph <= !ph;
	if (ph && speed_in != 16'h0000 && dir_in != DIR_STOP &&
		!(dir_in == DIR_CW && pos == 0)) begin
		nx = (dir_in == DIR_CCW) ? pos + 1 : pos - 1;
		pos <= nx;
		step_out <= 1'b1;
		z_out <= z_en_in && (nx % Z_EVERY == 0);
	end
end
assign dog_out = pos >= DOG_LO && pos <= DOG_HI;
endmodule

/* File: test_servo_jog_and_homing_modes.sv */
// Self-checking bench for the jog and homing block.
`timescale 1ns/1ns
module test_servo_jog_and_homing_modes;
import motion_pkg::*;
logic clk = 1'b0, srst = 1'b1, amode = 1'b0, fwd = 1'b0, rev = 1'b0;
logic son = 1'b0, z_en = 1'b1, pd = 1'b0;
logic step, dog, zp, jm, busy, done;
logic [4:0] tlo = 5'h00;
logic [2:0] thi = 3'h0;
jog_cfg_t jcfg = '0;
home_cfg_t hcfg = '0;
rot_dir_t dir, last = DIR_STOP;
rot_dir_t dq[$];
logic [31:0] hq[$];
int lq[$];
logic [15:0] spd;
logic [31:0] pos;
int n_errors = 0, tests_run = 0;
always #50 clk = ~clk;
servo_jog_and_homing_modes #(.STALL_CYCLES(20)) dut_u (.SYS_CLK_IN(clk),
	.SRST_IN(srst), .AUTO_MANUAL_SELECT_IN(amode),
	.TABLE_SELECT_LOW_BITS_IN(tlo), .TABLE_SELECT_HIGH_BITS_IN(thi),
	.FORWARD_START_IN(fwd), .REVERSE_START_IN(rev), .JOG_CFG_IN(jcfg),
	.HOME_CFG_IN(hcfg), .SERVO_ON_IN(son), .DOG_IN(dog), .Z_PULSE_IN(zp),
	.MOVE_STEP_IN(step), .DIR_OUT(dir), .SPEED_OUT(spd), .JOG_MODE_OUT(jm),
	.HOMING_BUSY_OUT(busy), .HOME_DONE_OUT(done), .POSITION_OUT(pos));
axis_model axis_u (.clk_in(clk), .z_en_in(z_en), .dir_in(dir),
	.speed_in(spd), .step_out(step), .dog_out(dog), .z_out(zp));
////////////////////////////////////////////////////////////////////////
task automatic cmp_dir(rot_dir_t e, rot_dir_t s);
	tests_run++;
	if (s !== e) begin
		n_errors++;
		$display("ERROR DIR_OUT exp %0d seen %0d", e, s);
	end
endtask
task automatic cmp_val(string n, logic [31:0] e, logic [31:0] s);
	tests_run++;
	if (s !== e) begin
		n_errors++;
		$display("ERROR %s exp %0h seen %0h", n, e, s);
	end
endtask
// Every direction change in jog mode must match the oldest note.
always @(posedge clk) begin
	pd <= done;
	last <= dir;
	if (!srst && jm === 1'b1 && dir !== last) begin
		cmp_dir(dq.size() ? dq.pop_front() : last, dir);
	end
	if (done === 1'b1 && pd !== 1'b1) begin
		cmp_val("POSITION_OUT", hq.size() ? hq.pop_front() : '1,
			pos);
		// Where the axis really stands when home is declared.
		cmp_val("axis home", lq.size() ? lq.pop_front() : '1,
			axis_u.pos);
	end
end
// A bounded wait; the speed must settle on exactly the expected value.
task automatic wait_spd(logic [15:0] v);
	for (int k = 0; k < 300 && spd !== v; k++) @(negedge clk);
	cmp_val("SPEED_OUT", {16'h0000, v}, {16'h0000, spd});
endtask
task automatic jog(logic m, logic f, logic b);
	@(negedge clk);
	jcfg.direction_map = m;
	jcfg.jog_speed = 16'($urandom_range(8, 2));
	jcfg.accel_time = 16'($urandom_range(3, 0));
	jcfg.decel_time = 16'($urandom_range(3, 0));
	{thi, tlo} = 8'($urandom);
	dq.push_back((f ^ m) ? DIR_CCW : DIR_CW);
	{fwd, rev} = {f, !f};
	wait_spd(jcfg.jog_speed);
	dq.push_back(DIR_STOP);
	{fwd, rev} = {b, b};
	wait_spd(16'h0000);
	repeat (4) @(negedge clk);
	{fwd, rev} = 2'b00;
	$display("test jog end");
endtask
// Each return must end with done raised and the position at zero.
task automatic home(logic [3:0] mth, logic dn, logic z, int loc);
	@(negedge clk);
	amode = 1'b1;
	{thi, tlo} = 8'h00;
	hcfg.method = mth;
	hcfg.dir_decrement = dn;
	z_en = z;
	hq.push_back(32'h0000_0000);
	lq.push_back(loc < 0 ? axis_u.pos : loc);
	@(negedge clk);
	if (mth == 4'h4) son = 1'b1;
	else fwd = 1'b1;
	for (int k = 0; k < 3000 && hq.size() != 0; k++) @(negedge clk);
	cmp_val("HOME_DONE_OUT", 32'h0, hq.size());
	hq.delete();
	lq.delete();
	{fwd, son} = 2'b00;
	// Let the axis come to rest so jog mode sees no stray turn.
	for (int k = 0; k < 300 && dir !== DIR_STOP; k++) @(negedge clk);
	@(negedge clk);
	amode = 1'b0;
	$display("test home %0d end", mth);
endtask
task automatic tally_and_finish();
	$display("checks %0d errors %0d", tests_run, n_errors);
	if (n_errors == 0 && tests_run > 0)
		$display("DONE - PASS");
	else
		$display("DONE - FAIL");
	$finish;
endtask
// Main sequence: jog every mapping, then each return method.
initial begin
	void'($urandom(96892));
	hcfg.shift_dist = 32'h0000_0003;
	hcfg.after_dog_dist = 32'h0000_0005;
	repeat (16) @(negedge clk);
	srst = 1'b0;
	for (int i = 0; i < 4; i++) jog(i[0], i[1], 1'b0);
	jog(1'b0, 1'b1, 1'b1);
	jog(1'b1, 1'b0, 1'b1);
	// Axis homes: dog 200..240, Z every 16, travel 5, shift 3.
	home(4'h4, 1'b0, 1'b1, -1);
	home(4'h0, 1'b0, 1'b1, 259);
	home(4'h1, 1'b1, 1'b1, 221);
	home(4'h5, 1'b1, 1'b0, 191);
	home(4'h3, 1'b1, 1'b1, 0);
	// Done stays high between returns, so a mid-run reset clears it first.
	@(negedge clk);
	srst = 1'b1;
	repeat (4) @(negedge clk);
	srst = 1'b0;
	jog(1'b0, 1'b1, 1'b0);
	hcfg.absolute_system = 1'b1;
	home(4'h2, 1'b0, 1'b1, -1);
	tally_and_finish();
end
// Cuts a hang short well past the expected run length.
initial begin
	#2000000;
	n_errors++;
	$display("ERROR watchdog exp finish seen timeout");
	tally_and_finish();
end
endmodule
